/* pdr_pkg.sv */
// Constants and types shared by the protocol MAC reset control block.
// Assumes a 32-bit AXI4-Lite register bus with a 16-bit byte address.
package pdr_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [15:0] PDR_CTL_INDEX = 16'h1A8B;
    localparam logic [15:0] PDR_CTL_ADDR = {PDR_CTL_INDEX[13:0], 2'b00};
    localparam int PDR_WORD_LSB = 2;
    localparam int PDR_ADDR_W = 16;
    localparam int PDR_DATA_W = 32;
    localparam int PDR_CTL_W = 8;

    // ------------------------------------------------------------------
    // Field layout of mac_reset_control
    // ------------------------------------------------------------------
    localparam int PDR_MAC_RST_BIT = 7;
    localparam int PDR_CODEC_RST_BIT = 6;
    localparam int PDR_PROTO_RST_BIT = 0;
    localparam logic [7:0] PDR_CTL_MASK = 8'hC1;
    localparam logic [7:0] PDR_CTL_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------------
    localparam logic [1:0] PDR_RESP_OKAY = 2'h0;
    localparam logic [1:0] PDR_RESP_DECERR = 2'h3;
    localparam logic [31:0] PDR_RDATA_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Write channel states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PDR_WR_IDLE = 2'b01,
        PDR_WR_RESP = 2'b10
    } pdr_wr_state_t;

endpackage

/* pdr_ctl_if.sv */
// Carrier for the three software reset levels between register file and fan-out.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface pdr_ctl_if;
    logic mac_rst;
    logic codec_rst;
    logic proto_rst;
    modport src (output mac_rst, output codec_rst, output proto_rst);
    modport dst (input mac_rst, input codec_rst, input proto_rst);
endinterface

/* pdr_reset_fanout.sv */
// Turns the software reset levels into registered resets for each MAC sub-block.
// Assumes the levels come from flip-flops on ref_clk_i.
`timescale 1ns/100ps
module pdr_reset_fanout (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    pdr_ctl_if.dst ctl,
    input wire logic rx_enable_i,
    output logic mac_reset_o,
    output logic codec_reset_o,
    output logic codec_config_reset_o,
    output logic rx_fsm_reset_o,
    output logic tx_fsm_reset_o,
    output logic tx_serializer_reset_o,
    output logic tx_request_clear_o,
    output logic keep_reset_o,
    output logic hr_detect_enable_o
);

    // ------------------------------------------------------------------
    // Reset outputs
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mac_reset_o <= 1'b1;
            codec_reset_o <= 1'b1;
            codec_config_reset_o <= 1'b1;
            keep_reset_o <= 1'b1;
        end
        else
        begin
            mac_reset_o <= ctl.mac_rst;
            codec_reset_o <= ctl.mac_rst | ctl.codec_rst;
            codec_config_reset_o <= ctl.mac_rst;
            keep_reset_o <= ctl.mac_rst;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rx_fsm_reset_o <= 1'b1;
            tx_fsm_reset_o <= 1'b1;
            tx_serializer_reset_o <= 1'b1;
            tx_request_clear_o <= 1'b1;
        end
        else
        begin
            rx_fsm_reset_o <= ctl.mac_rst | ctl.proto_rst;
            tx_fsm_reset_o <= ctl.mac_rst | ctl.proto_rst;
            tx_serializer_reset_o <= ctl.mac_rst | ctl.proto_rst;
            tx_request_clear_o <= ctl.mac_rst | ctl.proto_rst;
        end
    end

    // ------------------------------------------------------------------
    // Hard and cable reset detection arming
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            hr_detect_enable_o <= 1'b0;
        end
        else if (ctl.mac_rst)
        begin
            hr_detect_enable_o <= 1'b0;
        end
        else if (rx_enable_i)
        begin
            hr_detect_enable_o <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_mac_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ctl.mac_rst |=> (mac_reset_o && codec_reset_o && rx_fsm_reset_o && keep_reset_o))
        else $error("MAC reset not applied to all sub-blocks.");

    chk_codec_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ctl.codec_rst |=> codec_reset_o)
        else $error("Codec reset not applied.");

    chk_codec_config: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (ctl.codec_rst && !ctl.mac_rst) |=> !codec_config_reset_o)
        else $error("Codec reset disturbed codec configuration.");

    chk_proto_targets: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ctl.proto_rst |=> (rx_fsm_reset_o && tx_fsm_reset_o && tx_serializer_reset_o
            && tx_request_clear_o))
        else $error("Protocol reset missed a target.");

    chk_proto_spare: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (ctl.proto_rst && !ctl.mac_rst) |=> (!keep_reset_o && !codec_reset_o)
            || $past(ctl.codec_rst))
        else $error("Protocol reset touched preserved logic.");

    chk_proto_release: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (!ctl.mac_rst && !ctl.proto_rst) [*2] |=> !rx_fsm_reset_o && !tx_request_clear_o)
        else $error("Protocol reset not released.");

    chk_detect_keep: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (hr_detect_enable_o && ctl.proto_rst && !ctl.mac_rst) |=> hr_detect_enable_o)
        else $error("Protocol reset dropped detection enable.");

endmodule

/* pdr_mac_mac_reset_control.sv */
// AXI4-Lite slave holding the MAC reset control register and its reset fan-out.
// Assumes a single clock and one outstanding read and write from the master.
`timescale 1ns/100ps
module pdr_mac_mac_reset_control (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] s_axi_awaddr_i,
    input wire logic [2:0] s_axi_awprot_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [15:0] s_axi_araddr_i,
    input wire logic [2:0] s_axi_arprot_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic rx_enable_i,
    output logic mac_reset_o,
    output logic codec_reset_o,
    output logic codec_config_reset_o,
    output logic rx_fsm_reset_o,
    output logic tx_fsm_reset_o,
    output logic tx_serializer_reset_o,
    output logic tx_request_clear_o,
    output logic keep_reset_o,
    output logic hr_detect_enable_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    pdr_pkg::pdr_wr_state_t wr_state_reg;
    logic aw_have_reg;
    logic w_have_reg;
    logic [15:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic [1:0] bresp_reg;
    logic [7:0] ctl_reg;
    logic [7:0] ctl_next;
    logic wr_commit;
    logic wr_hit;
    logic rd_hit;
    logic rd_take;
    logic [7:0] rd_value;

    pdr_ctl_if ctl_bus ();

    // ------------------------------------------------------------------
    // Write address and data capture
    // ------------------------------------------------------------------
    assign s_axi_awready_o = (wr_state_reg == pdr_pkg::PDR_WR_IDLE) && !aw_have_reg;
    assign s_axi_wready_o = (wr_state_reg == pdr_pkg::PDR_WR_IDLE) && !w_have_reg;
    assign s_axi_bvalid_o = (wr_state_reg == pdr_pkg::PDR_WR_RESP);
    assign s_axi_bresp_o = bresp_reg;
    assign wr_commit = (wr_state_reg == pdr_pkg::PDR_WR_IDLE) && aw_have_reg && w_have_reg;
    assign wr_hit = (aw_addr_reg[15:pdr_pkg::PDR_WORD_LSB]
        == pdr_pkg::PDR_CTL_ADDR[15:pdr_pkg::PDR_WORD_LSB]);

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            aw_have_reg <= 1'b0;
            aw_addr_reg <= 16'h0000;
        end
        else if (s_axi_awvalid_i && s_axi_awready_o)
        begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr_i;
        end
        else if (s_axi_bvalid_o && s_axi_bready_i)
        begin
            aw_have_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            w_have_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end
        else if (s_axi_wvalid_i && s_axi_wready_o)
        begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata_i;
            w_strb_reg <= s_axi_wstrb_i;
        end
        else if (s_axi_bvalid_o && s_axi_bready_i)
        begin
            w_have_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Write state and response
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_state_reg <= pdr_pkg::PDR_WR_IDLE;
            bresp_reg <= pdr_pkg::PDR_RESP_OKAY;
        end
        else
        begin
            case (wr_state_reg)
                pdr_pkg::PDR_WR_IDLE:
                begin
                    if (wr_commit)
                    begin
                        wr_state_reg <= pdr_pkg::PDR_WR_RESP;
                        bresp_reg <= wr_hit ? pdr_pkg::PDR_RESP_OKAY : pdr_pkg::PDR_RESP_DECERR;
                    end
                end
                pdr_pkg::PDR_WR_RESP:
                begin
                    if (s_axi_bready_i)
                    begin
                        wr_state_reg <= pdr_pkg::PDR_WR_IDLE;
                    end
                end
                default:
                begin
                    wr_state_reg <= pdr_pkg::PDR_WR_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Reset control register
    // ------------------------------------------------------------------
    always_comb
    begin
        ctl_next = ctl_reg;
        if (wr_commit && wr_hit && w_strb_reg[0])
        begin
            ctl_next = w_data_reg[7:0] & pdr_pkg::PDR_CTL_MASK;
        end
    end

    // The register sits only on the chip reset, never on the MAC reset it drives.
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctl_reg <= pdr_pkg::PDR_CTL_RESET;
        end
        else
        begin
            ctl_reg <= ctl_next;
        end
    end

    assign ctl_bus.mac_rst = ctl_reg[pdr_pkg::PDR_MAC_RST_BIT];
    assign ctl_bus.codec_rst = ctl_reg[pdr_pkg::PDR_CODEC_RST_BIT];
    assign ctl_bus.proto_rst = ctl_reg[pdr_pkg::PDR_PROTO_RST_BIT];

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    assign s_axi_arready_o = !s_axi_rvalid_o;
    assign rd_take = s_axi_arvalid_i && s_axi_arready_o;
    assign rd_hit = (s_axi_araddr_i[15:pdr_pkg::PDR_WORD_LSB]
        == pdr_pkg::PDR_CTL_ADDR[15:pdr_pkg::PDR_WORD_LSB]);
    assign rd_value = ctl_reg & pdr_pkg::PDR_CTL_MASK;

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= pdr_pkg::PDR_RDATA_ZERO;
            s_axi_rresp_o <= pdr_pkg::PDR_RESP_OKAY;
        end
        else if (rd_take)
        begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rd_hit ? {24'h00_0000, rd_value} : pdr_pkg::PDR_RDATA_ZERO;
            s_axi_rresp_o <= rd_hit ? pdr_pkg::PDR_RESP_OKAY : pdr_pkg::PDR_RESP_DECERR;
        end
        else if (s_axi_rready_i)
        begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Reset fan-out
    // ------------------------------------------------------------------
    pdr_reset_fanout u_fanout (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .ctl(ctl_bus.dst),
        .rx_enable_i(rx_enable_i),
        .mac_reset_o(mac_reset_o),
        .codec_reset_o(codec_reset_o),
        .codec_config_reset_o(codec_config_reset_o),
        .rx_fsm_reset_o(rx_fsm_reset_o),
        .tx_fsm_reset_o(tx_fsm_reset_o),
        .tx_serializer_reset_o(tx_serializer_reset_o),
        .tx_request_clear_o(tx_request_clear_o),
        .keep_reset_o(keep_reset_o),
        .hr_detect_enable_o(hr_detect_enable_o)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_write_commit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (wr_commit && wr_hit && w_strb_reg[0])
            |=> ctl_reg == ($past(w_data_reg[7:0]) & pdr_pkg::PDR_CTL_MASK) && s_axi_bvalid_o)
        else $error("Control write not committed.");

    chk_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h00_0000 && s_axi_rdata_o[5:1] == 5'h00)
        else $error("Reserved read bits not zero.");

    chk_mac_bit_keep: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $fell(ctl_reg[pdr_pkg::PDR_MAC_RST_BIT]) |-> $past(wr_commit) && $past(wr_hit))
        else $error("MAC reset bit cleared without a write.");

    chk_bit_to_reset: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(ctl_reg[pdr_pkg::PDR_MAC_RST_BIT]) |=> mac_reset_o [*1] ##1 1'b1)
        else $error("MAC reset output late.");

    chk_read_answer: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (rd_take && rd_hit) |=> s_axi_rvalid_o && s_axi_rresp_o == pdr_pkg::PDR_RESP_OKAY
            && s_axi_rdata_o[7:0] == $past(rd_value))
        else $error("Register read answer wrong.");

    chk_proto_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ctl_bus.proto_rst
            |=> tx_request_clear_o && tx_fsm_reset_o)
        else $error("Protocol reset did not clear transmit requests.");

    chk_rx_path_keep: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (ctl_bus.proto_rst && !ctl_bus.mac_rst && !ctl_bus.codec_rst)
            |=> !keep_reset_o && !codec_reset_o)
        else $error("Protocol reset disturbed the receive path.");

    chk_tx_timer_keep: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (ctl_bus.proto_rst && !ctl_bus.mac_rst)
            |=> !keep_reset_o && !mac_reset_o)
        else $error("Protocol reset disturbed transmit timing.");

    chk_bist_pm_keep: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (ctl_bus.proto_rst && !ctl_bus.mac_rst)
            |=> !keep_reset_o && !codec_config_reset_o)
        else $error("Protocol reset disturbed self-test or power control.");

    chk_codec_path: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (ctl_bus.codec_rst && !ctl_bus.mac_rst && !ctl_bus.proto_rst)
            |=> codec_reset_o && !rx_fsm_reset_o && !keep_reset_o)
        else $error("Codec reset reached the wrong logic.");

    chk_write_blocked: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (wr_commit && !(wr_hit && w_strb_reg[0]))
            |=> $stable(ctl_reg) && s_axi_bvalid_o)
        else $error("Ignored write changed the control register.");

    chk_write_decerr: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (wr_commit && !wr_hit)
            |=> s_axi_bvalid_o && s_axi_bresp_o == pdr_pkg::PDR_RESP_DECERR)
        else $error("Unmapped write not refused.");

    chk_read_decerr: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (rd_take && !rd_hit)
            |=> s_axi_rvalid_o && s_axi_rresp_o == pdr_pkg::PDR_RESP_DECERR
                && s_axi_rdata_o == pdr_pkg::PDR_RDATA_ZERO)
        else $error("Unmapped read not refused.");

    chk_write_refused: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("Write accepted while response pending.");

endmodule

/* tb_top.sv */
// Self-checking bench for the MAC reset control register and its reset fan-out.
// Assumes the design checks its own timing with embedded assertions.
`timescale 1ns/100ps
module tb_top;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [15:0] awaddr = 16'h0000;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [15:0] araddr = 16'h0000;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic rx_en = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic mac_r, codec_r, cfg_r, rxf_r, txf_r, ser_r, clr_r, keep_r, hr_en;
    logic [7:0] outs;
    logic [1:0] resp;
    logic [31:0] rd;
    int n_mismatch = 0;
    int comparisons = 0;

    assign outs = {mac_r, codec_r, cfg_r, rxf_r, txf_r, ser_r, clr_r, keep_r};

    always #25 ref_clk_i = ~ref_clk_i;

    pdr_mac_mac_reset_control DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arprot_i(3'h0), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .rx_enable_i(rx_en), .mac_reset_o(mac_r),
        .codec_reset_o(codec_r), .codec_config_reset_o(cfg_r), .rx_fsm_reset_o(rxf_r),
        .tx_fsm_reset_o(txf_r), .tx_serializer_reset_o(ser_r),
        .tx_request_clear_o(clr_r), .keep_reset_o(keep_r), .hr_detect_enable_o(hr_en));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] exp_outs(input logic [7:0] v);
        return {v[7], v[7] | v[6], v[7], {4{v[7] | v[0]}}, v[7]};
    endfunction

    task automatic axi_write(input logic [15:0] a, input logic [31:0] d,
                             input logic [3:0] s, output logic [1:0] r);
        logic aw_hit, w_hit, b_hit;
        int n;
        n = 0;
        b_hit = 1'b0;
        r = 2'h0;
        @(posedge ref_clk_i);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_hit && n < 100)
        begin
            @(negedge ref_clk_i);
            aw_hit = awvalid & awready;
            w_hit = wvalid & wready;
            b_hit = bvalid & bready;
            r = bresp;
            @(posedge ref_clk_i);
            if (aw_hit)
                awvalid <= 1'b0;
            if (w_hit)
                wvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        if (!b_hit)
            check(32'h0000_0000, 32'h0000_0001);
        @(negedge ref_clk_i);
    endtask

    task automatic axi_read(input logic [15:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        logic ar_hit, r_hit;
        int n;
        n = 0;
        r_hit = 1'b0;
        @(posedge ref_clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_hit && n < 100)
        begin
            @(negedge ref_clk_i);
            ar_hit = arvalid & arready;
            r_hit = rvalid & rready;
            d = rdata;
            r = rresp;
            @(posedge ref_clk_i);
            if (ar_hit)
                arvalid <= 1'b0;
            n++;
        end
        rready <= 1'b0;
        if (!r_hit)
            check(32'h0000_0000, 32'h0000_0001);
    endtask

    task automatic pulse_rx_enable();
        @(posedge ref_clk_i);
        rx_en <= 1'b1;
        @(posedge ref_clk_i);
        rx_en <= 1'b0;
        @(negedge ref_clk_i);
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset_state();
        check(outs, 8'h00);
        check(hr_en, 1'b0);
        axi_read(pdr_pkg::PDR_CTL_ADDR, rd, resp);
        check(rd, 32'h0000_0000);
        check(resp, pdr_pkg::PDR_RESP_OKAY);
        $display("test_reset_state done");
    endtask

    task automatic test_bit_table();
        logic [7:0] tbl [5] = '{8'h01, 8'h40, 8'h41, 8'h80, 8'hC1};
        foreach (tbl[i])
        begin
            axi_write(pdr_pkg::PDR_CTL_ADDR, {24'h000000, tbl[i]}, 4'h1, resp);
            check(resp, pdr_pkg::PDR_RESP_OKAY);
            check(outs, exp_outs(tbl[i]));
            axi_read(pdr_pkg::PDR_CTL_ADDR, rd, resp);
            check(rd, {24'h000000, tbl[i]});
        end
        axi_write(pdr_pkg::PDR_CTL_ADDR, 32'h0000_0000, 4'h1, resp);
        check(outs, 8'h00);
        $display("test_bit_table done");
    endtask

    task automatic test_protocol_reset();
        pulse_rx_enable();
        check(hr_en, 1'b1);
        axi_write(pdr_pkg::PDR_CTL_ADDR, 32'h0000_0001, 4'h1, resp);
        check({rxf_r, txf_r, ser_r}, 3'h7);
        check(clr_r, 1'b1);
        check(keep_r, 1'b0);
        check({mac_r, codec_r, cfg_r}, 3'h0);
        check(hr_en, 1'b1);
        axi_write(pdr_pkg::PDR_CTL_ADDR, 32'h0000_0040, 4'h1, resp);
        check({codec_r, cfg_r}, 2'h2);
        check(hr_en, 1'b1);
        axi_write(pdr_pkg::PDR_CTL_ADDR, 32'h0000_0080, 4'h1, resp);
        check(hr_en, 1'b0);
        axi_write(pdr_pkg::PDR_CTL_ADDR, 32'h0000_0000, 4'h1, resp);
        check(outs, 8'h00);
        $display("test_protocol_reset done");
    endtask

    task automatic test_reserved_and_decode();
        axi_write(pdr_pkg::PDR_CTL_ADDR, 32'hFFFF_FF3E, 4'hF, resp);
        axi_read(pdr_pkg::PDR_CTL_ADDR, rd, resp);
        check(rd, 32'h0000_0000);
        axi_write(pdr_pkg::PDR_CTL_ADDR, 32'h0000_00FF, 4'hE, resp);
        check(resp, pdr_pkg::PDR_RESP_OKAY);
        check(outs, 8'h00);
        axi_write(pdr_pkg::PDR_CTL_ADDR + 16'h0004, 32'h0000_00FF, 4'h1, resp);
        check(resp, pdr_pkg::PDR_RESP_DECERR);
        check(outs, 8'h00);
        axi_read(pdr_pkg::PDR_CTL_ADDR + 16'h0004, rd, resp);
        check(resp, pdr_pkg::PDR_RESP_DECERR);
        check(rd, 32'h0000_0000);
        $display("test_reserved_and_decode done");
    endtask

    task automatic test_chip_reset();
        axi_write(pdr_pkg::PDR_CTL_ADDR, 32'h0000_0080, 4'h1, resp);
        check(outs, 8'hFF);
        @(posedge ref_clk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        check(outs, 8'hFF);
        @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        check(outs, 8'h00);
        axi_read(pdr_pkg::PDR_CTL_ADDR, rd, resp);
        check(rd, 32'h0000_0000);
        $display("test_chip_reset done");
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        test_reset_state();
        test_bit_table();
        test_protocol_reset();
        test_reserved_and_decode();
        test_chip_reset();
        complete_run();
    end

    initial
    begin
        repeat (5000) @(posedge ref_clk_i);
        n_mismatch++;
        complete_run();
    end
endmodule
